// ==== src/input_sync.sv ====
// three-stage synchroniser for the input pins, change counted when stages two and three agree
`timescale 1ns/1ps
module input_sync (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic [slave_io_pkg::DATA_W-1:0]   pins,
  output logic      [slave_io_pkg::DATA_W-1:0]   level
);
  logic [slave_io_pkg::DATA_W-1:0] s1;
  logic [slave_io_pkg::DATA_W-1:0] s2;
  logic [slave_io_pkg::DATA_W-1:0] s3;
  logic [slave_io_pkg::DATA_W-1:0] next_level;

  always_comb begin
    next_level = level;
    for (int i = 0; i < slave_io_pkg::DATA_W; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end else begin
      s1    <= pins;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule : input_sync

// ==== src/safety_input_path.sv ====
// input inversion, standard path and safety path with the reply selector
`timescale 1ns/1ps
module safety_input_path (
  input  wire logic [3:0] phys_in,
  input  wire logic       joint_invert,
  input  wire logic [3:0] per_input_invert_mask,
  input  wire logic       safety_flag,
  output logic      [3:0] reply_data
);
  logic [3:0] inv;
  logic [3:0] std_path;
  logic [3:0] logical;
  logic [3:0] safe_path;
  logic       not_safety;

  // mask stays on physical pins, so swap follows inversion
  assign inv        = phys_in ^ per_input_invert_mask ^ {4{joint_invert}};
  assign not_safety = ~safety_flag;
  // standard path tied to one so a single stuck selector shows up
  assign std_path   = inv | {4{safety_flag}};
  assign logical    = {inv[2], inv[3], inv[1], inv[0]};
  assign safe_path  = {logical[3:1],
                       logical[0] ^ (logical[1] & logical[2] & logical[3])};
  // one 2:1 selector per bit ahead of the send selector
  assign reply_data = (safe_path & {4{safety_flag}}) | (std_path & {4{not_safety}});
endmodule : safety_input_path

// ==== src/slave_data_port.sv ====
// slave data port: banked outputs in extended address mode and safety input path
`timescale 1ns/1ps
module slave_data_port (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       call_valid,
  input  wire logic       call_is_exchange,
  input  wire logic       call_is_parameter,
  input  wire logic       call_own_address,
  input  wire logic [3:0] call_info,
  input  wire logic       ext_addr_mode,
  input  wire logic       slave_is_b,
  input  wire logic       banked_four_output_flag,
  input  wire logic       safety_flag,
  input  wire logic       sync_io_flag,
  input  wire logic [3:0] input_filter_select,
  input  wire logic       joint_invert,
  input  wire logic [3:0] per_input_invert_mask,
  input  wire logic [3:0] input_pins,
  output logic            output_pin_zero,
  output logic            output_pin_one,
  output logic            output_pin_two,
  output logic            output_pin_three,
  output logic            data_strobe,
  output logic            reply_valid,
  output logic            reply_bit_zero,
  output logic            reply_bit_one,
  output logic            reply_bit_two,
  output logic            reply_bit_three,
  output logic            exchange_blocked
);
  logic [3:0] in_level;
  logic [3:0] reply_data;
  logic [3:0] outputs;
  logic [3:0] next_outputs;
  logic [1:0] staged_low_outputs;
  logic [1:0] next_staged;
  logic       prev_sel;
  logic       next_prev_sel;
  logic       next_blocked;
  logic       next_strobe;
  logic       next_reply_valid;
  logic [3:0] reply;
  logic [3:0] next_reply;
  logic       ab_match;
  logic       exchange_hit;
  logic       banked;
  logic       bank_sel;
  logic       safety_conflict;

  input_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pins   (input_pins),
    .level  (in_level)
  );

  safety_input_path u_safe (
    .phys_in               (in_level),
    .joint_invert          (joint_invert),
    .per_input_invert_mask (per_input_invert_mask),
    .safety_flag           (safety_flag),
    .reply_data            (reply_data)
  );

  assign ab_match = !ext_addr_mode || (call_info[slave_io_pkg::BIT_I3] == slave_is_b);
  assign exchange_hit = call_valid && call_is_exchange && call_own_address
                        && ab_match;
  assign banked   = ext_addr_mode && banked_four_output_flag;
  assign bank_sel = call_info[slave_io_pkg::BIT_I2];
  assign safety_conflict = safety_flag && (sync_io_flag || (|input_filter_select));

  always_comb begin
    next_outputs     = outputs;
    next_staged      = staged_low_outputs;
    next_prev_sel    = prev_sel;
    next_blocked     = exchange_blocked;
    next_strobe      = 1'b0;
    next_reply_valid = 1'b0;
    next_reply       = reply;
    if (call_valid && call_is_parameter && call_own_address && ab_match
        && !safety_conflict) begin
      next_blocked = 1'b0;
    end
    if (safety_conflict) begin
      next_blocked = slave_io_pkg::BLOCK_RST;
    end
    if (exchange_hit && !exchange_blocked) begin
      next_reply_valid = 1'b1;
      next_reply       = reply_data;
      if (banked) begin
        next_prev_sel = bank_sel;
        if (bank_sel) begin
          next_staged = call_info[slave_io_pkg::BIT_I1:slave_io_pkg::BIT_I0];
        end else if (prev_sel) begin
          // both banks issued together on the falling edge of select
          next_outputs = {call_info[slave_io_pkg::BIT_I1:slave_io_pkg::BIT_I0],
                          staged_low_outputs};
          next_strobe  = 1'b1;
        end
      end else begin
        next_outputs = ext_addr_mode ? {outputs[3], call_info[2:0]} : call_info;
        next_strobe  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outputs            <= slave_io_pkg::OUT_RST;
      staged_low_outputs <= slave_io_pkg::STAGE_RST;
      prev_sel           <= slave_io_pkg::BANK_SEL_RST;
      exchange_blocked   <= slave_io_pkg::BLOCK_RST;
      data_strobe        <= 1'b0;
      reply_valid        <= 1'b0;
      reply              <= '0;
    end else begin
      outputs            <= next_outputs;
      staged_low_outputs <= next_staged;
      prev_sel           <= next_prev_sel;
      exchange_blocked   <= next_blocked;
      data_strobe        <= next_strobe;
      reply_valid        <= next_reply_valid;
      reply              <= next_reply;
    end
  end

  assign output_pin_zero  = outputs[0];
  assign output_pin_one   = outputs[1];
  assign output_pin_two   = outputs[2];
  assign output_pin_three = outputs[3];
  assign reply_bit_zero   = reply[0];
  assign reply_bit_one    = reply[1];
  assign reply_bit_two    = reply[2];
  assign reply_bit_three  = reply[3];

  // check-only copy of the inverted pins, the reference for the reply checks
  logic [3:0] in_inverted;
  assign in_inverted = in_level ^ per_input_invert_mask ^ {4{joint_invert}};

  // banked and plain output path
  a_strobe_edge: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && banked && !bank_sel && prev_sel)
    |=> data_strobe)
    else $error("strobe missing on select fall");
  a_no_strobe_high: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && banked && bank_sel)
    |=> !data_strobe && $stable(outputs))
    else $error("outputs moved on select high");
  a_first_low: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && banked && !bank_sel && !prev_sel)
    |=> !data_strobe)
    else $error("strobe without preceding select high");
  a_bank_load: assert property (
    @(posedge clk) disable iff (!resetn)
    data_strobe && $past(banked)
    |-> outputs[1:0] == $past(staged_low_outputs))
    else $error("bank one not from staging");
  a_bank_high: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && banked && !bank_sel && prev_sel)
    |=> outputs[3:2] == $past(call_info[slave_io_pkg::BIT_I1:slave_io_pkg::BIT_I0]))
    else $error("bank two not from call bits");
  a_stage_load: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && banked && bank_sel)
    |=> staged_low_outputs == $past(call_info[slave_io_pkg::BIT_I1:slave_io_pkg::BIT_I0]))
    else $error("staging not loaded");
  a_stage_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && banked && !bank_sel)
    |=> $stable(staged_low_outputs))
    else $error("staging moved on select low");
  a_select_track: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && banked)
    |=> prev_sel == $past(bank_sel))
    else $error("toggle detector missed select");
  a_outputs_strobe: assert property (
    @(posedge clk) disable iff (!resetn)
    $changed(outputs)
    |-> data_strobe)
    else $error("outputs changed without strobe");
  a_refused_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !exchange_hit
    |=> $stable(staged_low_outputs) && $stable(prev_sel) && $stable(outputs))
    else $error("bank state moved without accepted call");
  a_std_strobe: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && !banked)
    |=> data_strobe)
    else $error("plain exchange gave no strobe");
  a_std_load: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && !ext_addr_mode)
    |=> outputs == $past(call_info))
    else $error("standard outputs not from call");
  a_ext_pin_three: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked && ext_addr_mode && !banked_four_output_flag)
    |=> $stable(outputs[3]))
    else $error("output three moved in extended mode");

  // reply path
  a_reply_every: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked)
    |=> reply_valid)
    else $error("no reply");
  a_reply_data: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_hit && !exchange_blocked)
    |=> reply == $past(reply_data))
    else $error("reply not all four input bits");
  a_reply_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(exchange_hit && !exchange_blocked)
    |=> $stable(reply))
    else $error("reply bits moved without exchange");
  a_reply_source: assert property (
    @(posedge clk) disable iff (!resetn)
    reply_valid
    |-> $past(exchange_hit && !exchange_blocked))
    else $error("reply without accepted call");
  a_wrong_ab: assert property (
    @(posedge clk) disable iff (!resetn)
    (ext_addr_mode && call_info[slave_io_pkg::BIT_I3] != slave_is_b)
    |=> !reply_valid && $stable(prev_sel))
    else $error("other slave call accepted");
  a_not_own_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    (call_valid && !call_own_address)
    |=> !reply_valid && !data_strobe)
    else $error("foreign address call accepted");
  a_b_slave_hit: assert property (
    @(posedge clk) disable iff (!resetn)
    (call_valid && call_is_exchange && call_own_address && ext_addr_mode
     && call_info[slave_io_pkg::BIT_I3] == slave_is_b && !exchange_blocked)
    |=> reply_valid)
    else $error("own slave call ignored");

  // safety input path
  a_std_forced: assert property (
    @(posedge clk) disable iff (!resetn)
    (!safety_flag && exchange_hit && !exchange_blocked)
    |=> reply == $past(in_inverted))
    else $error("standard path wrong");
  a_std_select: assert property (
    @(posedge clk) disable iff (!resetn)
    !safety_flag
    |-> reply_data == in_inverted)
    else $error("selector not on standard path");
  a_safe_route: assert property (
    @(posedge clk) disable iff (!resetn)
    safety_flag
    |-> reply_data[3:1] == {in_inverted[2], in_inverted[3], in_inverted[1]})
    else $error("safety path not selected");
  a_invert_pins: assert property (
    @(posedge clk) disable iff (!resetn)
    safety_flag
    |-> reply_data[2] == (in_level[3] ^ per_input_invert_mask[3] ^ joint_invert))
    else $error("invert mask not on physical pin");
  a_safe_combine: assert property (
    @(posedge clk) disable iff (!resetn)
    safety_flag
    |-> reply_data[0] == (in_inverted[0] ^ (&in_inverted[3:1])))
    else $error("bit zero combine on path");
  a_safe_bit0: assert property (
    @(posedge clk) disable iff (!resetn)
    (safety_flag && exchange_hit && !exchange_blocked)
    |=> reply[0] == $past(in_inverted[0] ^ (&in_inverted[3:1])))
    else $error("bit zero combine");
  a_safe_swap: assert property (
    @(posedge clk) disable iff (!resetn)
    (safety_flag && exchange_hit && !exchange_blocked)
    |=> reply[3:1] == $past({in_inverted[2], in_inverted[3], in_inverted[1]}))
    else $error("inputs two and three not swapped");

  // exchange block
  a_blocked_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    exchange_blocked
    |=> !reply_valid && !data_strobe)
    else $error("reply while blocked");
  a_unblock_param: assert property (
    @(posedge clk) disable iff (!resetn)
    (call_valid && call_is_parameter && call_own_address && ab_match && !safety_conflict)
    |=> !exchange_blocked)
    else $error("parameter call did not unblock");
  a_block_sticky: assert property (
    @(posedge clk) disable iff (!resetn)
    (exchange_blocked && !(call_valid && call_is_parameter && call_own_address))
    |=> exchange_blocked)
    else $error("block cleared without parameter call");
  a_strobe_source: assert property (
    @(posedge clk) disable iff (!resetn)
    data_strobe
    |-> $past(exchange_hit && !exchange_blocked))
    else $error("strobe without accepted exchange");
  a_param_no_reply: assert property (
    @(posedge clk) disable iff (!resetn)
    (call_valid && call_is_parameter && !call_is_exchange)
    |=> !reply_valid)
    else $error("parameter call answered as exchange");
  a_conflict_block: assert property (
    @(posedge clk) disable iff (!resetn)
    safety_conflict
    |=> exchange_blocked)
    else $error("conflict did not block");
  a_conflict_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    (safety_conflict && $past(safety_conflict))
    |=> !reply_valid)
    else $error("reply during safety conflict");

  // main scenarios
  c_bank_event: cover property (@(posedge clk)
    data_strobe && banked);
  c_unblock: cover property (@(posedge clk)
    $fell(exchange_blocked));
  c_safe_reply: cover property (@(posedge clk)
    reply_valid && safety_flag);
  c_plain_strobe: cover property (@(posedge clk)
    data_strobe && !ext_addr_mode);
  c_conflict_hold: cover property (@(posedge clk)
    safety_conflict && exchange_blocked);
endmodule : slave_data_port

// ==== src/slave_io_pkg.sv ====
// shared constants for the slave data port bank and safety path
package slave_io_pkg;
  localparam int          DATA_W        = 4;
  localparam int          BANK_W        = 2;
  localparam int          BIT_I0        = 0;
  localparam int          BIT_I1        = 1;
  localparam int          BIT_I2        = 2;
  localparam int          BIT_I3        = 3;
  localparam logic        BANK_SEL_RST  = 1'h0;
  localparam logic [3:0]  OUT_RST       = 4'h0;
  localparam logic [1:0]  STAGE_RST     = 2'h0;
  localparam logic        BLOCK_RST     = 1'h1;
  localparam int          SYNC_STAGES   = 3;
endpackage : slave_io_pkg

// ==== verification/call_master.sv ====
// behavioural bus master issuing parameter and data exchange calls
`timescale 1ns/1ps
module call_master (
  input  wire logic       clk,
  output logic            call_valid,
  output logic            call_is_exchange,
  output logic            call_is_parameter,
  output logic            call_own_address,
  output logic [3:0]      call_info
);
  initial begin
    call_valid = 1'b0;
    {call_is_exchange, call_is_parameter, call_own_address, call_info} = 7'h00;
  end
  // one call, launched just after an edge, taken at the next one
  task automatic send(input logic exch, input logic [3:0] info, input logic own);
    @(posedge clk);
    #1;
    call_valid = 1'b1;
    {call_is_exchange, call_is_parameter, call_own_address, call_info} = {exch, ~exch, own, info};
    @(posedge clk);
    #1;
    call_valid = 1'b0;
    // released bus shows the inverse so stale fields never look valid
    {call_is_exchange, call_is_parameter, call_own_address, call_info} = ~{exch, ~exch, own, info};
  endtask : send
  // safe code generator: swaps inputs two and three, presents 1111 for 1110
  function automatic logic [3:0] gen_pins(input logic [3:0] want);
    logic [3:0] w;
    w = (want == 4'hE) ? 4'hF : want;
    return {w[2], w[3], w[1:0]};
  endfunction : gen_pins
endmodule : call_master

// ==== verification/tb_top.sv ====
// self-checking bench for the slave data port
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0, resetn = 1'b0, ext = 1'b0, is_b = 1'b0, bank = 1'b0;
  logic       safe = 1'b0, sync = 1'b0, jinv = 1'b0, strobe, rvalid, blocked;
  logic [3:0] filt = 4'h0, mask = 4'h0, pins = 4'h0, dout, rply, a, b, w;
  wire        cv, cx, cp, co;
  wire  [3:0] ci;
  int         n_mismatch = 0, n_compared = 0, cycles = 0, seed = 32'hbc102e32;
  always #20 clk = ~clk;
  call_master u_call_master (.clk(clk), .call_valid(cv), .call_is_exchange(cx),
    .call_is_parameter(cp), .call_own_address(co), .call_info(ci));
  slave_data_port u_slave_data_port (.clk(clk), .resetn(resetn), .call_valid(cv),
    .call_is_exchange(cx), .call_is_parameter(cp), .call_own_address(co), .call_info(ci),
    .ext_addr_mode(ext), .slave_is_b(is_b), .banked_four_output_flag(bank), .safety_flag(safe),
    .sync_io_flag(sync), .input_filter_select(filt), .joint_invert(jinv),
    .per_input_invert_mask(mask), .input_pins(pins), .output_pin_zero(dout[0]),
    .output_pin_one(dout[1]), .output_pin_two(dout[2]), .output_pin_three(dout[3]),
    .data_strobe(strobe), .reply_valid(rvalid), .reply_bit_zero(rply[0]),
    .reply_bit_one(rply[1]), .reply_bit_two(rply[2]), .reply_bit_three(rply[3]),
    .exchange_blocked(blocked));
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [3:0] exp_reply(input logic [3:0] p, input logic j,
                                           input logic [3:0] m, input logic s);
    logic [3:0] l;
    l = p ^ m ^ {4{j}};
    if (s) begin
      l = {l[2], l[3], l[1:0]};
      l[0] = l[0] ^ (&l[3:1]);
    end
    return l;
  endfunction : exp_reply
  task automatic restart();
    #1 resetn = 1'b0;
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
  endtask : restart
  task automatic xchg(input logic [3:0] info);
    u_call_master.send(1'b1, info, 1'b1);
  endtask : xchg
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    restart();
    check("blocked", blocked, 4'h1);
    xchg(4'h0);
    check("reply_valid", rvalid, 4'h0);
    u_call_master.send(1'b0, 4'h0, 1'b1);
    check("blocked", blocked, 4'h0);
    xchg(4'hA);
    check("outputs", dout, 4'hA);
    ext = 1'b1;
    xchg(4'h5);
    check("strobe", strobe, 4'h1);
    check("outputs", dout, 4'hD);
    is_b = 1'b1;
    xchg(4'h8);
    check("reply_valid", rvalid, 4'h1);
    is_b = 1'b0;
    bank = 1'b1;
    xchg(4'h0);
    check("strobe", strobe, 4'h0);
    check("reply_valid", rvalid, 4'h1);
    repeat (20) begin
      {a, b} = $random(seed);
      xchg({2'b01, a[1:0]});
      check("strobe", strobe, 4'h0);
      check("reply_valid", rvalid, 4'h1);
      xchg({2'b11, b[1:0]});
      check("reply_valid", rvalid, 4'h0);
      u_call_master.send(1'b1, {2'b00, b[1:0]}, 1'b0);
      check("reply_valid", rvalid, 4'h0);
      xchg({2'b00, b[1:0]});
      check("strobe", strobe, 4'h1);
      check("outputs", dout, {b[1:0], a[1:0]});
      xchg({2'b00, a[1:0]});
      check("strobe", strobe, 4'h0);
      check("outputs", dout, {b[1:0], a[1:0]});
    end
    repeat (24) begin
      {a, w, pins, mask, jinv, safe} = $random(seed);
      if (a[0]) {jinv, mask, pins} = {5'h00, u_call_master.gen_pins(w)};
      repeat (6) @(posedge clk);
      xchg(4'h0);
      check("reply", rply, exp_reply(pins, jinv, mask, safe));
      if (a[0] && safe && w != 4'hF) check("safe code", rply, w);
    end
    safe = 1'b1;
    {jinv, mask, pins} = {5'h00, u_call_master.gen_pins(4'hE)};
    repeat (6) @(posedge clk);
    xchg(4'h0);
    check("safe code", rply, 4'hE);
    for (int k = 0; k < 2; k++) begin
      {sync, filt} = k ? 5'h04 : 5'h10;
      restart();
      u_call_master.send(1'b0, 4'h0, 1'b1);
      xchg(4'h0);
      check("blocked", blocked, 4'h1);
      check("reply_valid", rvalid, 4'h0);
    end
    report_and_stop();
  end
endmodule : tb_top
